// ==== fwsr_cfg.svh ====
`ifndef FWSR_CFG_SVH
`define FWSR_CFG_SVH
// Software register offsets (byte addresses, one word each).
`define FWSR_OFF_CTRL 8'h00
`define FWSR_OFF_ADDR 8'h04
`define FWSR_OFF_STAT 8'h08
`define FWSR_OFF_DATA 8'h0C
// Control register fields.
`define FWSR_CTRL_START 0
`define FWSR_CTRL_RESET 1
`define FWSR_CTRL_ABORT 2
`define FWSR_CTRL_SECTOR 3
// Status register fields.
`define FWSR_ST_BUSY 0
`define FWSR_ST_DONE 1
`define FWSR_ST_FAIL 2
`define FWSR_ST_WINDOW 3
`define FWSR_ST_ABORTED 4
`define FWSR_ST_READY 5
// Status bit positions in the flash data byte.
`define FWSR_BIT_POLL 7
`define FWSR_BIT_TOGGLE 6
`define FWSR_BIT_TIMEOUT 5
`define FWSR_BIT_WINDOW 3
`define FWSR_BIT_STOGGLE 2
`define FWSR_BIT_ABORT 1
// Flash bus timing, cycles of the 10 ns clock.
`define FWSR_CLK_NS 10
`define FWSR_T_ACC_NS 100
`define FWSR_ACC_CYC ((`FWSR_T_ACC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_T_WR_NS 50
`define FWSR_WR_CYC ((`FWSR_T_WR_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_T_GAP_NS 30
`define FWSR_GAP_CYC ((`FWSR_T_GAP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
// Reset command word and the abort reset sequence.
`define FWSR_CMD_RESET 16'h00F0
`define FWSR_UNLOCK_A 12'h555
`define FWSR_UNLOCK_B 12'h2AA
`define FWSR_DATA_AA 16'h00AA
`define FWSR_DATA_55 16'h0055
`endif

// ==== fwsr_pkg.sv ====
package fwsr_pkg;
    typedef enum logic [1:0] {FWSR_IDLE, FWSR_READ, FWSR_WRITE, FWSR_GAP} fwsr_bus_t;
    typedef enum logic [3:0] {FWSR_S_IDLE, FWSR_S_RD1, FWSR_S_RD2, FWSR_S_EVAL, FWSR_S_RD3,
                              FWSR_S_EVAL2, FWSR_S_RST, FWSR_S_AB1, FWSR_S_AB2,
                              FWSR_S_AB3, FWSR_S_WIN} fwsr_seq_t;
endpackage : fwsr_pkg

// ==== fwsr_cyc_if.sv ====
`timescale 1ns/1ps
interface fwsr_cyc_if #(parameter int AW = 22, parameter int DW = 16);
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic done;
    logic [DW-1:0] rdata;
    modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
    modport bus (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fwsr_cyc_if

// ==== fwsr_bus_cycle.sv ====
`timescale 1ns/1ps
`include "fwsr_cfg.svh"
module fwsr_bus_cycle
    import fwsr_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Cycle request
    fwsr_cyc_if.bus cyc,
    // Flash pins
    output logic chip_select_n,
    output logic output_strobe_n,
    output logic write_strobe_n,
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_in
);
    localparam logic [3:0] ACC = 4'(`FWSR_ACC_CYC);
    localparam logic [3:0] WRC = 4'(`FWSR_WR_CYC);
    localparam logic [3:0] GAP = 4'(`FWSR_GAP_CYC);
    fwsr_bus_t st_q;
    logic [3:0] cnt_q;
    logic [DW-1:0] rd_q;
    logic [AW-1:0] a_q;
    logic [DW-1:0] w_q;
    wire last = (cnt_q == 4'h1);

    // A gap with both strobes high separates cycles so each read is a new read cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= FWSR_IDLE;
            cnt_q <= 4'h0;
            rd_q <= '0;
            a_q <= '0;
            w_q <= '0;
        end
        else if (clk_en)
        begin
            unique case (st_q)
                FWSR_IDLE:
                    if (cyc.req)
                    begin
                        st_q <= cyc.wr ? FWSR_WRITE : FWSR_READ;
                        cnt_q <= cyc.wr ? WRC : ACC;
                        a_q <= cyc.addr;
                        w_q <= cyc.wdata;
                    end
                FWSR_READ, FWSR_WRITE:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (last)
                    begin
                        if (st_q == FWSR_READ)
                            rd_q <= flash_dq_in;
                        st_q <= FWSR_GAP;
                        cnt_q <= GAP;
                    end
                end
                FWSR_GAP:
                begin
                    cnt_q <= cnt_q - 4'h1;
                    if (last)
                        st_q <= FWSR_IDLE;
                end
            endcase
        end
    end

    assign cyc.done = clk_en && (st_q == FWSR_GAP) && last;
    assign cyc.rdata = rd_q;
    assign chip_select_n = !(st_q == FWSR_READ || st_q == FWSR_WRITE);
    assign output_strobe_n = (st_q != FWSR_READ);
    assign write_strobe_n = (st_q != FWSR_WRITE);
    assign flash_addr = a_q;
    assign flash_dq_out = w_q;
    assign flash_dq_oe = (st_q == FWSR_WRITE);
endmodule : fwsr_bus_cycle

// ==== fwsr_host.sv ====
// Functional notes
// - Host reads status twice and compares; unchanged toggle means complete.
// - Toggling with timeout bit high: recheck, still toggling means fail and reset.
// - Resuming polling after other work restarts from the first read.
// - After timeout the host writes the reset command.
// - Sector erase commands closer than 50 us need no window check.
// - Host checks window bit before and after each added sector command; this host reads it only after a completed poll with the sector bit set.
// - Buffer abort bit set on abort; host sends the abort reset sequence.
// - Host polls at a valid address, the last loaded buffer address.
`timescale 1ns/1ps
`include "fwsr_cfg.svh"
module fwsr_host
    import fwsr_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins
    output logic chip_select_n,
    output logic output_strobe_n,
    output logic write_strobe_n,
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_in,
    input wire logic ready_busy_out
);
    fwsr_cyc_if #(.AW(AW), .DW(DW)) cyc ();

    fwsr_bus_cycle #(.AW(AW), .DW(DW)) u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cyc(cyc.bus),
        .chip_select_n(chip_select_n),
        .output_strobe_n(output_strobe_n),
        .write_strobe_n(write_strobe_n),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in)
    );

    fwsr_seq_t st_q;
    logic [AW-1:0] poll_addr_q;
    logic [DW-1:0] first_q;
    logic [DW-1:0] last_q;
    logic busy_q;
    logic done_q;
    logic fail_q;
    logic window_q;
    logic aborted_q;
    logic sector_q;
    logic [31:0] rdata_q;

    wire wr_ctrl = reg_wr && (reg_addr == `FWSR_OFF_CTRL);
    wire wr_addr = reg_wr && (reg_addr == `FWSR_OFF_ADDR);
    wire go_poll = wr_ctrl && reg_wdata[`FWSR_CTRL_START];
    wire go_reset = wr_ctrl && reg_wdata[`FWSR_CTRL_RESET];
    wire go_abort = wr_ctrl && reg_wdata[`FWSR_CTRL_ABORT];
    wire idle = (st_q == FWSR_S_IDLE);
    wire cyc_done = cyc.done;
    wire [DW-1:0] rd = cyc.rdata;

    // Sequence requests: status reads at the poll address, writes for recovery.
    wire is_write = (st_q == FWSR_S_RST) || (st_q == FWSR_S_AB1) ||
                    (st_q == FWSR_S_AB2) || (st_q == FWSR_S_AB3);
    assign cyc.req = !idle && (st_q != FWSR_S_EVAL) && (st_q != FWSR_S_EVAL2);
    assign cyc.wr = is_write;
    assign cyc.addr = (st_q == FWSR_S_AB1 || st_q == FWSR_S_AB3) ? AW'(`FWSR_UNLOCK_A) :
                      (st_q == FWSR_S_AB2) ? AW'(`FWSR_UNLOCK_B) :
                      (st_q == FWSR_S_RST) ? '0 : poll_addr_q;
    assign cyc.wdata = (st_q == FWSR_S_AB1) ? DW'(`FWSR_DATA_AA) :
                       (st_q == FWSR_S_AB2) ? DW'(`FWSR_DATA_55) : DW'(`FWSR_CMD_RESET);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= FWSR_S_IDLE;
            poll_addr_q <= '0;
            first_q <= '0;
            last_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            window_q <= 1'b0;
            aborted_q <= 1'b0;
            sector_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_addr)
                poll_addr_q <= AW'(reg_wdata);
            unique case (st_q)
                FWSR_S_IDLE:
                    if (go_poll)
                    begin
                        // Every new poll starts from its first read.
                        st_q <= FWSR_S_RD1;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        fail_q <= 1'b0;
                        aborted_q <= 1'b0;
                        // Software that spaces its erase commands tightly may skip the window read.
                        sector_q <= reg_wdata[`FWSR_CTRL_SECTOR];
                    end
                    else if (go_reset)
                    begin
                        st_q <= FWSR_S_RST;
                        busy_q <= 1'b1;
                    end
                    else if (go_abort)
                    begin
                        st_q <= FWSR_S_AB1;
                        busy_q <= 1'b1;
                    end
                FWSR_S_RD1:
                    if (cyc_done)
                    begin
                        first_q <= rd;
                        st_q <= FWSR_S_RD2;
                    end
                FWSR_S_RD2:
                    if (cyc_done)
                    begin
                        last_q <= rd;
                        st_q <= FWSR_S_EVAL;
                    end
                FWSR_S_EVAL:
                begin
                    // Compare the last two reads: RD1 or the previous RD2, and RD2.
                    if (!(last_q[`FWSR_BIT_TOGGLE] ^ first_q[`FWSR_BIT_TOGGLE]))
                    begin
                        st_q <= sector_q ? FWSR_S_WIN : FWSR_S_IDLE;
                        busy_q <= sector_q;
                        done_q <= !sector_q;
                    end
                    else if (last_q[`FWSR_BIT_ABORT])
                    begin
                        aborted_q <= 1'b1;
                        st_q <= FWSR_S_AB1;
                    end
                    else if (last_q[`FWSR_BIT_TIMEOUT])
                    begin
                        first_q <= last_q;
                        st_q <= FWSR_S_RD3;
                    end
                    else
                    begin
                        first_q <= last_q;
                        st_q <= FWSR_S_RD2;
                    end
                end
                FWSR_S_RD3:
                    if (cyc_done)
                    begin
                        last_q <= rd;
                        st_q <= FWSR_S_EVAL2;
                    end
                FWSR_S_EVAL2:
                    if (last_q[`FWSR_BIT_TOGGLE] ^ first_q[`FWSR_BIT_TOGGLE])
                    begin
                        fail_q <= 1'b1;
                        st_q <= FWSR_S_RST;
                    end
                    else
                    begin
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        st_q <= FWSR_S_IDLE;
                    end
                FWSR_S_WIN:
                    // Window bit sampled after acceptance is confirmed.
                    if (cyc_done)
                    begin
                        window_q <= rd[`FWSR_BIT_WINDOW];
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        st_q <= FWSR_S_IDLE;
                    end
                FWSR_S_RST:
                    if (cyc_done)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= FWSR_S_IDLE;
                    end
                FWSR_S_AB1:
                    if (cyc_done)
                        st_q <= FWSR_S_AB2;
                FWSR_S_AB2:
                    if (cyc_done)
                        st_q <= FWSR_S_AB3;
                FWSR_S_AB3:
                    if (cyc_done)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= FWSR_S_IDLE;
                    end
                default:
                    st_q <= FWSR_S_IDLE;
            endcase
        end
    end

    // Read mux; data appears the cycle after the strobe.
    wire [31:0] stat_word = {26'h0, ready_busy_out, aborted_q, window_q, fail_q, done_q,
                             busy_q};
    wire [31:0] rd_mux = (reg_addr == `FWSR_OFF_ADDR) ? 32'(poll_addr_q) :
                         (reg_addr == `FWSR_OFF_STAT) ? stat_word :
                         (reg_addr == `FWSR_OFF_DATA) ? {16'h0, 16'(last_q)} : 32'h0;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0;
        else if (clk_en && reg_rd)
            rdata_q <= rd_mux;
    end
    assign reg_rdata = rdata_q;
endmodule : fwsr_host

// ==== fwsr_host_assertions.sv ====
`timescale 1ns/1ps
module fwsr_host_assertions #(
    parameter int AW = 22,
    parameter int DW = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Flash pins
    input wire logic chip_select_n,
    input wire logic output_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [AW-1:0] flash_addr,
    input wire logic [DW-1:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic [DW-1:0] flash_dq_in,
    input wire logic ready_busy_out
);
    // Frozen cycles are skipped so a stalled strobe is not taken for a long one.
    default clocking @(posedge clk iff clk_en); endclocking
    default disable iff (!rst_n);
    a_no_overlap: assert property (output_strobe_n || write_strobe_n)
        else $error("read and write strobes overlap");
    a_cs_frames: assert property (!(output_strobe_n && write_strobe_n) |-> !chip_select_n)
        else $error("strobe without chip select");
    a_drive_write: assert property (!write_strobe_n |-> flash_dq_oe)
        else $error("write without data drive");
    a_release_read: assert property (!output_strobe_n |-> !flash_dq_oe)
        else $error("data driven during read");
    a_read_length: assert property ($fell(output_strobe_n) |->
        (!output_strobe_n)[*8] ##1 (!output_strobe_n)[*2] ##1 output_strobe_n)
        else $error("read strobe length wrong");
    a_write_length: assert property ($fell(write_strobe_n) |->
        (!write_strobe_n)[*5] ##1 write_strobe_n)
        else $error("write strobe length wrong");
    a_cycle_gap: assert property ($rose(chip_select_n) |-> chip_select_n[*3])
        else $error("gap between cycles too short");
    a_write_hold: assert property (!write_strobe_n && !$fell(write_strobe_n) |->
        $stable(flash_dq_out) && $stable(flash_addr))
        else $error("write data moved under strobe");
    a_read_addr: assert property (!output_strobe_n && !$fell(output_strobe_n) |->
        $stable(flash_addr))
        else $error("read address moved under strobe");
endmodule : fwsr_host_assertions
bind fwsr_host fwsr_host_assertions #(.AW(AW), .DW(DW)) fwsr_host_assertions_i (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_n(chip_select_n),
    .output_strobe_n(output_strobe_n), .write_strobe_n(write_strobe_n),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out));

// ==== fwsr_flash_model.sv ====
`timescale 1ns/1ps
module fwsr_flash_model (
    // Flash pins
    input wire logic chip_select_n,
    input wire logic output_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    output logic [15:0] dq,
    output logic ready_busy_out,
    // Scenario control
    input wire logic arm,
    input wire logic [7:0] busy_reads,
    input wire logic tmo,
    input wire logic abt,
    input wire logic win,
    output logic [7:0] wr_cnt
);
    int cnt = 0;
    logic hold = 1'b0;
    logic tog = 1'b0;
    logic stog = 1'b0;
    initial
    begin
        dq = 16'h0000;
        wr_cnt = 8'h00;
    end
    // A failed or aborted operation keeps toggling until a reset command.
    always @(posedge arm)
    begin
        cnt = busy_reads;
        hold = tmo | abt;
    end
    assign ready_busy_out = !(cnt > 0 || hold);
    // Pins are looked at 1 ns into the strobe so the edge order never matters.
    always @(negedge output_strobe_n)
    begin
        #1;
        if (!chip_select_n && (cnt > 0 || hold))
        begin
            tog = ~tog;
            if (flash_addr[21:15] == 7'h00)
                stog = ~stog;
            if (!hold)
                cnt = cnt - 1;
            dq = {8'h00, 1'b1, tog, tmo, 2'h0, stog, abt, 1'b0};
        end
        else if (!chip_select_n)
            dq = {12'h000, win, 3'h0};
    end
    // A released bus must not look like the last word read.
    always @(posedge output_strobe_n)
        dq = ~dq;
    always @(negedge write_strobe_n)
    begin
        #1;
        if (!chip_select_n)
        begin
            wr_cnt = wr_cnt + 8'h01;
            if (flash_dq_out[7:0] == 8'hF0)
            begin
                cnt = 0;
                hold = 1'b0;
            end
        end
    end
endmodule : fwsr_flash_model

// ==== fwsr_host_tb_top.sv ====
`timescale 1ns/1ps
`include "fwsr_cfg.svh"
module fwsr_host_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ce = 1'b1;
    logic [31:0] reg_rdata;
    logic cs_n, oe_n, we_n, dq_oe, rb, arm, tmo, abt, win;
    logic [21:0] fa;
    logic [15:0] dq_o, dq_i;
    logic [7:0] busy_reads, wr_cnt, w0;
    logic [31:0] d;
    int errors = 0;
    int compares = 0;
    initial {arm, tmo, abt, win, busy_reads} = 12'h000;
    always #5 clk = ~clk;
    fwsr_host #(.AW(22), .DW(16)) fwsr_host_i (
        .clk(clk), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_n(cs_n),
        .output_strobe_n(oe_n), .write_strobe_n(we_n), .flash_addr(fa), .flash_dq_out(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .ready_busy_out(rb));
    fwsr_flash_model fwsr_flash_model_i (
        .chip_select_n(cs_n), .output_strobe_n(oe_n), .write_strobe_n(we_n), .flash_addr(fa),
        .flash_dq_out(dq_o), .dq(dq_i), .ready_busy_out(rb), .arm(arm),
        .busy_reads(busy_reads), .tmo(tmo), .abt(abt), .win(win), .wr_cnt(wr_cnt));
    task automatic close_out;
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic wait_idle;
        for (int i = 0; i < 400; i++)
        begin
            rd(`FWSR_OFF_STAT);
            if (d[`FWSR_ST_BUSY] === 1'b0)
                return;
        end
        errors++;
        close_out();
    endtask : wait_idle
    // Sets up the flash model's next operation, then starts a poll at word 0.
    task automatic run(input logic [7:0] n, input logic t, input logic b, input logic [31:0] c);
        busy_reads <= n;
        tmo <= t;
        abt <= b;
        @(posedge clk);
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        w0 = wr_cnt;
        wr(`FWSR_OFF_ADDR, 32'h0);
        wr(`FWSR_OFF_CTRL, c);
    endtask : run
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`FWSR_OFF_STAT);
        chk("stat after reset", 32'h20, d);
        rd(8'h10);
        chk("unmapped read", 32'h0, d);
        // The reset order given while busy must be refused.
        run(8'h06, 1'b0, 1'b0, 32'h1);
        wr(`FWSR_OFF_CTRL, 32'h2);
        rd(`FWSR_OFF_STAT);
        chk("stat busy", 32'h01, d);
        // A low clock enable must hold the chip select and read strobe exactly where they stand.
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        d = {30'h0, cs_n, oe_n};
        repeat (40) @(posedge clk);
        chk("frozen strobes", d, {30'h0, cs_n, oe_n});
        ce <= 1'b1;
        wait_idle();
        chk("stat done", 32'h22, d);
        chk("writes in poll", {24'h0, w0}, {24'h0, wr_cnt});
        rd(`FWSR_OFF_DATA);
        chk("last word", 32'h0, d);
        for (int k = 0; k < 2; k++)
        begin
            win <= k[0];
            run(8'h03, 1'b0, 1'b0, 32'h9);
            wait_idle();
            chk("window stat", {26'h0, 1'b1, 1'b0, k[0], 3'h2}, d);
        end
        win <= 1'b0;
        run(8'h02, 1'b1, 1'b0, 32'h1);
        wait_idle();
        // The window bit from the last window check stays set until it is read again.
        chk("stat timeout", 32'h2E, d);
        chk("reset writes", {24'h0, w0 + 8'h01}, {24'h0, wr_cnt});
        tmo <= 1'b0;
        run(8'h02, 1'b0, 1'b1, 32'h1);
        wait_idle();
        chk("stat abort", 32'h3A, d);
        chk("abort writes", {24'h0, w0 + 8'h03}, {24'h0, wr_cnt});
        abt <= 1'b0;
        w0 = wr_cnt;
        wr(`FWSR_OFF_CTRL, 32'h2);
        wait_idle();
        chk("order writes", {24'h0, w0 + 8'h01}, {24'h0, wr_cnt});
        close_out();
    end
endmodule : fwsr_host_tb_top
